/* dv/fcsc_card_model.sv */
// Purpose: behavioural flash card seen from the register bank pins
// Assumes: pin changes land away from the controller clock edge
// Notes: ready/busy is open drain with a pull-up, ready while no die is enabled
`timescale 1ns/1ps
module fcsc_card_model (
    input wire logic [7:0] cardChipEnableN,
    output logic writeProtectDetectN,
    output logic cardAbsentPin,
    output logic flashReadyBusy
);
    logic wpSwitch = 1'b1;
    logic present = 1'b0;
    logic dieReady = 1'b1;
    // pull-up wins when no die drives the line
    assign flashReadyBusy = (&cardChipEnableN) ? 1'b1 : dieReady;
    assign writeProtectDetectN = wpSwitch;
    assign cardAbsentPin = ~present;
    task automatic set_card(input logic p);
        #1 present = p;
    endtask
    task automatic set_ready(input logic r);
        #1 dieReady = r;
    endtask
    task automatic set_wp(input logic w);
        #1 wpSwitch = w;
    endtask
endmodule // fcsc_card_model

/* dv/tb.sv */
// Purpose: self-checking bench for the status/control register bank
// Assumes: card model drives pins, core strobes driven here
// Notes: expectations come from an integer register image
`timescale 1ns/1ps
module tb
    import fcsc_pkg::*;
;
    localparam int IIS = 11;
    localparam int ICT = 12;
    localparam int ICS = 17;
    localparam int ICL = 18;
    localparam int IMK = 19;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic regWrEn = 1'b0;
    logic regRdEn = 1'b0;
    logic cmdPhase = 1'b0;
    logic xferActive = 1'b0;
    logic timerExpired = 1'b0;
    logic pageDone = 1'b0;
    logic pageVerifyOk = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWrData = 32'h0;
    logic [31:0] regRdData;
    logic writeProtectDetectN, cardAbsentPin, flashReadyBusy;
    logic [7:0] cardChipEnableN;
    logic cardWriteProtectOut, clockStop, xferComplete, irqOut;
    logic [15:0] xferCount;
    logic [31:0] em [0:31];
    logic [7:0] csv [11] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
        8'h18, 8'h0d, 8'h25};
    logic [7:0] a;
    logic [31:0] d;
    int bad_count = 0;
    int n_tests = 0;
    int seed = 32'ha2c5;
    wire [27:0] outs = {cardChipEnableN, cardWriteProtectOut, clockStop, irqOut,
        xferComplete, xferCount};

    initial begin
        forever #2 mclk = ~mclk;
    end

    fcsc_regs dut (.mclk(mclk), .rst_b(rst_b), .regAddr(regAddr), .regWrEn(regWrEn),
        .regRdEn(regRdEn), .regWrData(regWrData), .regRdData(regRdData),
        .writeProtectDetectN(writeProtectDetectN), .cardAbsentPin(cardAbsentPin),
        .flashReadyBusy(flashReadyBusy), .cmdPhase(cmdPhase), .xferActive(xferActive),
        .timerExpired(timerExpired), .pageDone(pageDone), .pageVerifyOk(pageVerifyOk),
        .cardChipEnableN(cardChipEnableN), .cardWriteProtectOut(cardWriteProtectOut),
        .clockStop(clockStop), .xferComplete(xferComplete), .xferCount(xferCount),
        .irqOut(irqOut));

    fcsc_card_model card (.cardChipEnableN(cardChipEnableN),
        .writeProtectDetectN(writeProtectDetectN), .cardAbsentPin(cardAbsentPin),
        .flashReadyBusy(flashReadyBusy));

    // ****************************************
    // reference image and checks
    // ****************************************
    function automatic logic [31:0] wmask(input logic [7:0] ad);
        case (ad)
            OFS_XFER_COUNT: return 32'h0000_ffff;
            OFS_SPARE_CFG_B: return 32'hffff_ffff;
            OFS_SPARE_CFG_A, OFS_CHIP_SELECT, OFS_PIN_CTRL, OFS_IRQ_MASK: return 32'h0000_00ff;
            default: return 32'h0;
        endcase
    endfunction

    function automatic logic [27:0] exp_out(input logic xc);
        logic [7:0] cs;
        logic [7:0] ct;
        logic [7:0] m;
        logic [7:0] ce;
        cs = em[ICS][7:0];
        ct = em[ICL][7:0];
        m = em[IMK][7:0];
        ce = 8'hff;
        // reserved indirect codes leave every die disabled
        if (ct[5]) ce = cs;
        else if (cs[7:4] == 4'h0) ce = ~(8'h01 << cs[2:0]);
        return {ce, ct[4], ct[7] & ~cmdPhase & ~xferActive,
            ~m[7] & |(em[IIS][4:3] & ~m[4:3]), xc, em[ICT][7:0], em[ICT][15:8]};
    endfunction

    task automatic tally_and_finish();
        $display("tests %0d bad %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t register got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_out(input logic [27:0] got, input logic [27:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t outputs got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
        @(posedge mclk);
        regAddr <= ad;
        regWrData <= wd;
        regWrEn <= 1'b1;
        @(posedge mclk);
        regWrEn <= 1'b0;
        if (ad == OFS_IRQ_STATUS) em[IIS] = em[IIS] & ~wd;
        else em[ad[6:2]] = wd & wmask(ad);
    endtask

    task automatic ck(input logic [7:0] ad);
        logic [31:0] got;
        logic [31:0] want;
        @(posedge mclk);
        regAddr <= ad;
        regRdEn <= 1'b1;
        @(posedge mclk);
        regRdEn <= 1'b0;
        #1 got = regRdData;
        want = em[ad[6:2]];
        // status follows the pins and core levels, not the image
        if (ad == OFS_CARD_STATUS) want = {24'h0, writeProtectDetectN, ST_RSVD_VAL,
            cardAbsentPin, timerExpired, cmdPhase, cmdPhase | xferActive, flashReadyBusy};
        cmp_reg(got, want);
    endtask

    task automatic wck(input logic [7:0] ad, input logic [31:0] wd);
        wr(ad, wd);
        ck(ad);
        cmp_out(outs, exp_out(1'b0));
    endtask

    task automatic init_image();
        for (int i = 0; i < 32; i++) em[i] = 32'h0;
        em[ICS] = 32'(CS_RST);
        em[IMK] = 32'(MSK_RST);
    endtask

    task automatic check_all();
        for (int k = 8'h28; k <= 8'h50; k += 4) ck(8'(k));
        cmp_out(outs, exp_out(1'b0));
    endtask

    task automatic pin_wait();
        // synchroniser plus flag and irq register take about six cycles
        repeat (8) @(posedge mclk);
    endtask

    initial begin
        repeat (20000) @(posedge mclk);
        bad_count++;
        tally_and_finish();
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        init_image();
        repeat (10) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (4) @(posedge mclk);
        check_all();
        repeat (40) begin
            a = 8'h28 + 8'(4 * ($unsigned($random(seed)) % 11));
            d = $random(seed);
            wck(a, d);
        end
        wr(OFS_PIN_CTRL, 32'h0);
        foreach (csv[k]) wck(OFS_CHIP_SELECT, 32'(csv[k]));
        wr(OFS_PIN_CTRL, 32'h20);
        repeat (4) wck(OFS_CHIP_SELECT, $random(seed));
        wr(OFS_PIN_CTRL, 32'h80);
        for (int k = 0; k < 8; k++) begin
            @(posedge mclk);
            {timerExpired, cmdPhase, xferActive} <= 3'(k);
            ck(OFS_CARD_STATUS);
            cmp_out(outs, exp_out(1'b0));
        end
        @(posedge mclk);
        {timerExpired, cmdPhase, xferActive} <= 3'h0;
        for (int k = 0; k < 4; k++) begin
            wr(OFS_PIN_CTRL, 32'(k[1]) << 6);
            @(posedge mclk);
            pageDone <= 1'b1;
            pageVerifyOk <= k[0];
            @(posedge mclk);
            pageDone <= 1'b0;
            #1 cmp_out(outs, exp_out(k[1] | k[0]));
        end
        wck(OFS_CHIP_SELECT, 32'h0);
        wck(OFS_IRQ_MASK, 32'(MSK_RST));
        card.set_card(1'b1);
        pin_wait();
        em[IIS][4] = 1'b1;
        ck(OFS_CARD_STATUS);
        wck(OFS_IRQ_STATUS, 32'h0);
        wck(OFS_IRQ_MASK, 32'h0);
        wck(OFS_IRQ_STATUS, 32'h10);
        card.set_ready(1'b0);
        pin_wait();
        ck(OFS_CARD_STATUS);
        wck(OFS_IRQ_MASK, 32'h08);
        card.set_ready(1'b1);
        pin_wait();
        em[IIS][3] = 1'b1;
        wck(OFS_IRQ_STATUS, 32'h0);
        wck(OFS_IRQ_MASK, 32'h0);
        wck(OFS_IRQ_STATUS, 32'h08);
        card.set_wp(1'b0);
        card.set_card(1'b0);
        pin_wait();
        em[IIS][4] = 1'b1;
        ck(OFS_CARD_STATUS);
        wck(OFS_IRQ_STATUS, 32'h0);
        // mid-run reset with the protect switch low and the card flag set
        @(posedge mclk);
        rst_b <= 1'b0;
        repeat (3) @(posedge mclk);
        #1 cmp_out(outs, {CS_RST, CTL_RST[CTL_WP], 3'h0, XC_RST});
        @(posedge mclk);
        rst_b <= 1'b1;
        init_image();
        pin_wait();
        check_all();
        tally_and_finish();
    end
endmodule // tb

/* hw/fcsc_pin_if.sv */
// Purpose: carries filtered card pin levels and their change pulses
// Assumes: single clock domain on the consumer side
// Notes: change is a one-cycle pulse per accepted edge
`timescale 1ns/1ps
interface fcsc_pin_if #(parameter int N = 3);
    logic [N-1:0] level;
    logic [N-1:0] change;
    modport src (output level, output change);
    modport dst (input level, input change);
endinterface

/* hw/fcsc_pin_sync.sv */
// Purpose: three-stage synchroniser with agreement filter for card pins
// Assumes: pins are asynchronous to mclk
// Notes: a change counts once stages two and three agree
`timescale 1ns/1ps
module fcsc_pin_sync #(
    parameter int N = 3,
    parameter logic [N-1:0] RESET_VAL = '1
) (
    input wire logic mclk,
    input wire logic rstSync_b,
    input wire logic [N-1:0] pinRaw,
    fcsc_pin_if.src pins
);
    logic [N-1:0] s1_ff;
    logic [N-1:0] s2_ff;
    logic [N-1:0] s3_ff;
    logic [N-1:0] level_ff;
    logic [N-1:0] change_ff;
    logic [N-1:0] nxt_level;

    if (N < 1) begin : g_chk
        $error("fcsc_pin_sync needs at least one pin");
    end

    // stage one feeds stage two only
    always_ff @(posedge mclk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            s1_ff <= RESET_VAL;
            s2_ff <= RESET_VAL;
            s3_ff <= RESET_VAL;
        end else begin
            s1_ff <= pinRaw;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    for (genvar i = 0; i < N; i++) begin : g_pin
        assign nxt_level[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : level_ff[i];
    end

    always_ff @(posedge mclk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            level_ff <= RESET_VAL;
            change_ff <= '0;
        end else begin
            level_ff <= nxt_level;
            change_ff <= nxt_level ^ level_ff;
        end
    end

    assign pins.level = level_ff;
    assign pins.change = change_ff;
endmodule // fcsc_pin_sync

/* hw/fcsc_pkg.sv */
// Purpose: shared constants of the flash card status/control register bank
// Assumes: 32-bit register words, byte offsets on an 8-bit address
// Notes: all offsets and field positions live here, and every reset value except those of the spare, interrupt flag and output registers
package fcsc_pkg;

    // ****************************************
    // register offsets
    // ****************************************
    localparam int FCSC_AW = 8;
    localparam logic [7:0] OFS_CARD_STATUS = 8'h28;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h2c;
    localparam logic [7:0] OFS_XFER_COUNT = 8'h30;
    localparam logic [7:0] OFS_SPARE_CFG_A = 8'h34;
    localparam logic [7:0] OFS_SPARE_CFG_B = 8'h38;
    localparam logic [7:0] OFS_SPARE_STS_A = 8'h3c;
    localparam logic [7:0] OFS_SPARE_STS_B = 8'h40;
    localparam logic [7:0] OFS_CHIP_SELECT = 8'h44;
    localparam logic [7:0] OFS_PIN_CTRL = 8'h48;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h4c;

    // ****************************************
    // field positions
    // ****************************************
    localparam int ST_WPD = 7;
    localparam int ST_CARD_ABSENT = 4;
    localparam int ST_TIMEOUT = 3;
    localparam int ST_CMD = 2;
    localparam int ST_ACTIVE = 1;
    localparam int ST_READY = 0;
    localparam logic [1:0] ST_RSVD_VAL = 2'h2;
    localparam int IRQ_CARD = 4;
    localparam int IRQ_READY = 3;
    localparam int CTL_CLKSTOP = 7;
    localparam int CTL_NOCHECK = 6;
    localparam int CTL_DIRECT = 5;
    localparam int CTL_WP = 4;
    localparam int MSK_ALL = 7;
    localparam int MSK_CARD = 4;
    localparam int MSK_READY = 3;

    // ****************************************
    // reset values and pin slots
    // ****************************************
    localparam logic [31:0] STATUS_RST = 32'h0000_00d1;
    localparam logic [7:0] CS_RST = 8'hff;
    localparam logic [7:0] CTL_RST = 8'h00;
    localparam logic [7:0] MSK_RST = 8'h80;
    localparam logic [15:0] XC_RST = 16'h0000;
    localparam int PIN_WPD = 0;
    localparam int PIN_ABSENT = 1;
    localparam int PIN_READY = 2;
    localparam int PIN_N = 3;
    localparam logic [2:0] PIN_RST = 3'h7;

endpackage

/* hw/fcsc_regs.sv */
// Purpose: status, interrupt, count, chip-select and pin-control registers
// Assumes: core signals cmdPhase/xferActive/timerExpired/pageDone on mclk
// Notes: reads return data one cycle after regRdEn
`timescale 1ns/1ps
module fcsc_regs
    import fcsc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [FCSC_AW-1:0] regAddr,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [31:0] regWrData,
    output logic [31:0] regRdData,
    input wire logic writeProtectDetectN,
    input wire logic cardAbsentPin,
    input wire logic flashReadyBusy,
    input wire logic cmdPhase,
    input wire logic xferActive,
    input wire logic timerExpired,
    input wire logic pageDone,
    input wire logic pageVerifyOk,
    output logic [7:0] cardChipEnableN,
    output logic cardWriteProtectOut,
    output logic clockStop,
    output logic xferComplete,
    output logic [15:0] xferCount,
    output logic irqOut
);
    // three pin slots and an address wide enough to reach the mask register
    if (PIN_N != 3 || FCSC_AW < 7) begin : g_chk
        $error("fcsc_regs needs three pins and a 7-bit address");
    end

    // ****************************************
    // reset release and pin filtering
    // ****************************************
    logic [1:0] rstPipe_ff;
    logic rstSync_b;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rstPipe_ff <= 2'h0;
        end else begin
            rstPipe_ff <= {rstPipe_ff[0], 1'b1};
        end
    end
    assign rstSync_b = rstPipe_ff[1];

    fcsc_pin_if #(.N(PIN_N)) pinBus ();

    fcsc_pin_sync #(.N(PIN_N), .RESET_VAL(PIN_RST)) uPinSync (
        .mclk(mclk),
        .rstSync_b(rstSync_b),
        .pinRaw({flashReadyBusy, cardAbsentPin, writeProtectDetectN}),
        .pins(pinBus.src)
    );

    // ****************************************
    // chip-enable decode
    // ****************************************
    // reserved indirect codes fall back to all chips off, the safe choice
    function automatic logic [7:0] fcscDecodeCe(input logic [7:0] sel, input logic direct);
        logic [7:0] ce;
        ce = 8'hff;
        if (direct) begin
            ce = sel;
        end else if (sel[7:5] == 3'h0 && !sel[4]) begin
            ce[sel[2:0]] = 1'b0;
        end
        return ce;
    endfunction

    // ****************************************
    // register storage
    // ****************************************
    logic [7:0] csSel_ff;
    logic [7:0] ctrl_ff;
    logic [7:0] mask_ff;
    logic [15:0] xferCnt_ff;
    logic [7:0] spareA_ff;
    logic [31:0] spareB_ff;
    logic irqCard_ff;
    logic irqReady_ff;
    logic [31:0] regRdData_ff;
    logic [7:0] cardChipEnableN_ff;
    logic cardWriteProtectOut_ff;
    logic clockStop_ff;
    logic xferComplete_ff;
    logic irq_ff;

    logic wrIrq;
    logic wrCnt;
    logic wrSpA;
    logic wrSpB;
    logic wrCs;
    logic wrCtl;
    logic wrMsk;
    logic cardEvt;
    logic readyEvt;
    logic nxt_irqCard;
    logic nxt_irqReady;
    logic nxt_irq;
    logic nxt_clockStop;
    logic nxt_xferComplete;
    logic [31:0] statusWord;
    logic [31:0] irqWord;
    logic [31:0] rdMux;

    assign wrIrq = regWrEn && regAddr == OFS_IRQ_STATUS;
    assign wrCnt = regWrEn && regAddr == OFS_XFER_COUNT;
    assign wrSpA = regWrEn && regAddr == OFS_SPARE_CFG_A;
    assign wrSpB = regWrEn && regAddr == OFS_SPARE_CFG_B;
    assign wrCs = regWrEn && regAddr == OFS_CHIP_SELECT;
    assign wrCtl = regWrEn && regAddr == OFS_PIN_CTRL;
    assign wrMsk = regWrEn && regAddr == OFS_IRQ_MASK;

    // status and spare status have no write decode at all
    always_ff @(posedge mclk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            csSel_ff <= CS_RST;
            ctrl_ff <= CTL_RST;
            mask_ff <= MSK_RST;
            xferCnt_ff <= XC_RST;
            spareA_ff <= 8'h00;
            spareB_ff <= 32'h0000_0000;
        end else begin
            if (wrCs) csSel_ff <= regWrData[7:0];
            if (wrCtl) ctrl_ff <= regWrData[7:0];
            if (wrMsk) mask_ff <= regWrData[7:0];
            if (wrCnt) xferCnt_ff <= regWrData[15:0];
            if (wrSpA) spareA_ff <= regWrData[7:0];
            if (wrSpB) spareB_ff <= regWrData;
        end
    end

    // ****************************************
    // interrupt status
    // ****************************************
    // an event in the clearing cycle wins over the clear
    assign cardEvt = pinBus.change[PIN_ABSENT];
    assign readyEvt = pinBus.change[PIN_READY] && pinBus.level[PIN_READY];
    assign nxt_irqCard = cardEvt || (irqCard_ff && !(wrIrq && regWrData[IRQ_CARD]));
    assign nxt_irqReady = readyEvt
        || (irqReady_ff && !(wrIrq && regWrData[IRQ_READY]));
    assign nxt_irq = !mask_ff[MSK_ALL]
        && ((irqCard_ff && !mask_ff[MSK_CARD])
        || (irqReady_ff && !mask_ff[MSK_READY]));

    always_ff @(posedge mclk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            irqCard_ff <= 1'b0;
            irqReady_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else begin
            irqCard_ff <= nxt_irqCard;
            irqReady_ff <= nxt_irqReady;
            irq_ff <= nxt_irq;
        end
    end

    // ****************************************
    // read path
    // ****************************************
    assign statusWord = {24'h0, pinBus.level[PIN_WPD], ST_RSVD_VAL,
        pinBus.level[PIN_ABSENT], timerExpired, cmdPhase,
        cmdPhase || xferActive, pinBus.level[PIN_READY]};
    assign irqWord = {27'h0, irqCard_ff, irqReady_ff, 3'h0};

    always_comb begin
        unique case (regAddr)
            OFS_CARD_STATUS: rdMux = statusWord;
            OFS_IRQ_STATUS: rdMux = irqWord;
            OFS_XFER_COUNT: rdMux = {16'h0, xferCnt_ff};
            OFS_SPARE_CFG_A: rdMux = {24'h0, spareA_ff};
            OFS_SPARE_CFG_B: rdMux = spareB_ff;
            OFS_CHIP_SELECT: rdMux = {24'h0, csSel_ff};
            OFS_PIN_CTRL: rdMux = {24'h0, ctrl_ff};
            OFS_IRQ_MASK: rdMux = {24'h0, mask_ff};
            default: rdMux = 32'h0000_0000;
        endcase
    end

    // ****************************************
    // pin-side outputs
    // ****************************************
    // clock may only stop once both command and data phases are over
    assign nxt_clockStop = ctrl_ff[CTL_CLKSTOP] && !cmdPhase && !xferActive;
    assign nxt_xferComplete = pageDone
        && (ctrl_ff[CTL_NOCHECK] || pageVerifyOk);

    always_ff @(posedge mclk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            regRdData_ff <= 32'h0000_0000;
            cardChipEnableN_ff <= 8'hff;
            cardWriteProtectOut_ff <= 1'b0;
            clockStop_ff <= 1'b0;
            xferComplete_ff <= 1'b0;
        end else begin
            regRdData_ff <= regRdEn ? rdMux : 32'h0000_0000;
            cardChipEnableN_ff <= fcscDecodeCe(csSel_ff, ctrl_ff[CTL_DIRECT]);
            cardWriteProtectOut_ff <= ctrl_ff[CTL_WP];
            clockStop_ff <= nxt_clockStop;
            xferComplete_ff <= nxt_xferComplete;
        end
    end

    assign regRdData = regRdData_ff;
    assign cardChipEnableN = cardChipEnableN_ff;
    assign cardWriteProtectOut = cardWriteProtectOut_ff;
    assign clockStop = clockStop_ff;
    assign xferComplete = xferComplete_ff;
    assign xferCount = {xferCnt_ff[7:0], xferCnt_ff[15:8]};
    assign irqOut = irq_ff;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstSync_b);

    sequence s_statusRead;
        regRdEn && regAddr == OFS_CARD_STATUS;
    endsequence
    sequence s_readyRise;
        pinBus.change[PIN_READY] && pinBus.level[PIN_READY];
    endsequence

    a_status_fixed: assert property (s_statusRead |=> regRdData[31:8] == 24'h0
        && regRdData[6:5] == ST_RSVD_VAL) else $error("status reserved bits wrong");
    a_status_ready: assert property (s_statusRead |=>
        regRdData[0] == $past(pinBus.level[PIN_READY])) else $error("ready bit wrong");
    a_status_absent: assert property (s_statusRead |=>
        regRdData[4] == $past(pinBus.level[PIN_ABSENT])) else $error("card bit wrong");
    a_status_busy: assert property (s_statusRead ##0 (cmdPhase && !xferActive) |=>
        regRdData[2:1] == 2'h3) else $error("busy bits wrong");
    a_ready_set: assert property (s_readyRise |=> irqReady_ff)
        else $error("busy-to-ready not flagged");
    a_card_sticky: assert property (cardEvt ##1 !(wrIrq && regWrData[IRQ_CARD]) [*2]
        |=> irqCard_ff) else $error("card flag lost");
    a_card_clear: assert property (irqCard_ff && wrIrq && regWrData[IRQ_CARD]
        && !cardEvt |=> !irqCard_ff) else $error("card flag not cleared");
    a_irq_global: assert property (mask_ff[MSK_ALL] |=> !irqOut)
        else $error("global mask ignored");
    a_irq_raise: assert property (irqReady_ff && !mask_ff[MSK_READY]
        && !mask_ff[MSK_ALL] |=> irqOut) else $error("interrupt not raised");
    a_ce_direct: assert property (ctrl_ff[CTL_DIRECT] |=>
        cardChipEnableN == $past(csSel_ff)) else $error("direct map wrong");
    a_ce_indirect: assert property (!ctrl_ff[CTL_DIRECT] && csSel_ff[7:4] == 4'h0 |=>
        $countones(~cardChipEnableN) == 1 && !cardChipEnableN[$past(csSel_ff[2:0])])
        else $error("indirect select wrong");
    a_ce_off: assert property (!ctrl_ff[CTL_DIRECT] && csSel_ff[7:4] == 4'h1
        |=> cardChipEnableN == 8'hff) else $error("chips not disabled");
    a_wp_drive: assert property ($changed(ctrl_ff[CTL_WP]) |=>
        cardWriteProtectOut == $past(ctrl_ff[CTL_WP])) else $error("write protect wrong");
    a_clk_stop: assert property ((cmdPhase || xferActive) |=> !clockStop)
        else $error("clock stopped while busy");
    a_page_done: assert property (xferComplete |-> $past(pageDone)
        && ($past(ctrl_ff[CTL_NOCHECK]) || $past(pageVerifyOk)))
        else $error("complete without check");
    a_status_wpd: assert property (s_statusRead |=>
        regRdData[ST_WPD] == $past(pinBus.level[PIN_WPD])) else $error("protect bit wrong");
    a_status_timer: assert property (s_statusRead |=>
        regRdData[ST_TIMEOUT] == $past(timerExpired)) else $error("timer bit wrong");
    a_status_cmd: assert property (s_statusRead |=>
        regRdData[ST_CMD] == $past(cmdPhase)) else $error("command bit wrong");
    a_status_active: assert property (s_statusRead ##0 xferActive |=>
        regRdData[ST_ACTIVE]) else $error("transfer bit wrong");
    a_ready_hold: assert property (irqReady_ff && !(wrIrq && regWrData[IRQ_READY])
        |=> irqReady_ff) else $error("ready flag lost");
    a_ready_clear: assert property (irqReady_ff && wrIrq && regWrData[IRQ_READY]
        && !readyEvt |=> !irqReady_ff) else $error("ready flag not cleared");
    a_count_swap: assert property (wrCnt |=> xferCount[15:8] == $past(regWrData[7:0])
        && xferCount[7:0] == $past(regWrData[15:8])) else $error("count bytes wrong");
    a_spare_zero: assert property (regRdEn && (regAddr == OFS_SPARE_STS_A
        || regAddr == OFS_SPARE_STS_B) |=> regRdData == 32'h0000_0000)
        else $error("reserved status not zero");
    a_irq_idle: assert property (!irqCard_ff && !irqReady_ff |=> !irqOut)
        else $error("interrupt without flag");
    a_irq_card: assert property (irqCard_ff && !mask_ff[MSK_CARD]
        && !mask_ff[MSK_ALL] |=> irqOut) else $error("card interrupt missing");
    a_card_mask: assert property (mask_ff[MSK_CARD]
        && !(irqReady_ff && !mask_ff[MSK_READY]) |=> !irqOut) else $error("card mask ignored");
    a_page_refuse: assert property (pageDone && !ctrl_ff[CTL_NOCHECK] && !pageVerifyOk
        |=> !xferComplete) else $error("complete without verify");
    a_clk_idle: assert property (ctrl_ff[CTL_CLKSTOP] && !cmdPhase && !xferActive
        |=> clockStop) else $error("clock not stopped");
endmodule // fcsc_regs
